// file: design/pbha_device.sv
// Device end: pointer, data port, selector and configuration registers over the 1 KB buffer
// Overview of operation
// - Page bit 7 picks data port read/write
// - Access against direction flag moves no data
// - Auto-step adds one byte or one word
// - Offset overflow wraps page or next page
// - Page write waits for offset write
// - Page and offset split by page size
// - Data access hits the pointed buffer byte
// - Host pairs bytes low address then high
// - Only low-then-high keeps word together
// - Byte order pin swaps paired word halves
// - Byte mode: one byte, upper zero
// - Selector picks indirect window register
// - Host never loads unused selector codes
// - Host sets selector before window access
// - Configuration reset values, online by strap
// - Bit 7 holds software reset
// - Going online pulses a software reset
// - Backplane bit picks signalling, default set
//
// Design decision made here: the APB register port.
module pbha_device
  import pbha_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset, active low
  pbha_bus_if.device bus, // Parallel host bus
  input wire logic wide_bus_select, // 16-bit bus when high
  input wire logic word_pairing_mode, // Pair bytes on 8-bit bus
  input wire logic byte_order_select, // Byte order of paired word
  input wire logic [1:0] page_size_code, // Page size code
  input wire logic online_strap, // Reset value of the online bit
  input wire logic [15:0] window_rdata, // Read data of the selected indirect register
  output logic [3:0] indirect_select, // Indirect register selection
  output logic window_write, // One-cycle write to the indirect register
  output logic [15:0] window_wdata, // Write data for the indirect register
  output logic sw_reset, // Software reset level
  output logic network_online, // Online bit
  output logic timeout_select_low, // Timeout select low bit
  output logic timeout_select_high, // Timeout select high bit
  output logic backplane_signalling // Backplane signalling when high
);
  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  logic [7:0] buf_mem [PBHA_BUF_BYTES];
  logic [2:0] page_flags_r; // dir_read, auto_step, wrap
  logic [PBHA_PAGE_W-1:0] page_pending_r;
  logic [PBHA_PTR_W-1:0] ptr_r;
  logic [3:0] sel_r;
  logic [7:0] cfg_r;
  logic pulse_reset_r;
  logic [7:0] pair_low_r;
  logic pair_open_r;
  logic [15:0] rdata_r;
  logic ack_r;
  logic strap_done_r;

  // Offset width from page size
  function automatic int offset_width(input logic [1:0] ps);
    return 8 - int'(ps);
  endfunction

  // Combine page and offset into one pointer, dropping unused page bits
  function automatic logic [PBHA_PTR_W-1:0] join_ptr(input logic [1:0] ps,
      input logic [PBHA_PAGE_W-1:0] pg, input logic [7:0] ofs);
    logic [PBHA_PTR_W-1:0] pmask;
    pmask = 10'h3FF >> (10 - offset_width(ps));
    return ((10'(pg) << offset_width(ps)) & ~pmask) | (10'(ofs) & pmask);
  endfunction

  // Next pointer after one auto step
  function automatic logic [PBHA_PTR_W-1:0] step_ptr(input logic [1:0] ps,
      input logic [PBHA_PTR_W-1:0] p, input logic [9:0] step, input logic wrap);
    logic [PBHA_PTR_W-1:0] pmask;
    logic [PBHA_PTR_W-1:0] sum;
    pmask = 10'h3FF >> (10 - offset_width(ps));
    sum = p + step;
    if (wrap) begin
      return sum;
    end else begin
      return (p & ~pmask) | (sum & pmask);
    end
  endfunction

  //----------------------------------------------------------------
  // Access decode
  //----------------------------------------------------------------
  logic acc;
  logic is_data;
  logic dir_read;
  logic data_ok;
  logic step_now;
  logic [9:0] step_size;
  logic pair_mode;
  assign acc = bus.strobe & ~ack_r;
  assign dir_read = page_flags_r[2];
  assign is_data = (bus.addr == PBHA_OFS_DATA_LO) || (bus.addr == PBHA_OFS_DATA_HI);
  assign pair_mode = ~wide_bus_select & word_pairing_mode;
  assign data_ok = acc & is_data & (bus.write != dir_read);
  assign step_size = (wide_bus_select | word_pairing_mode) ? PBHA_STEP_WORD : PBHA_STEP_BYTE;
  // Paired mode steps once per completed word
  assign step_now = data_ok & page_flags_r[1] &
      (~pair_mode | (bus.addr == PBHA_OFS_DATA_HI && pair_open_r));

  //----------------------------------------------------------------
  // Bus answer: one-cycle acknowledge after the strobe
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= acc;
    end
  end
  assign bus.ack = ack_r;
  assign bus.rdata = rdata_r;

  //----------------------------------------------------------------
  // Page register and pending page
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_flags_r <= 3'b000;
      page_pending_r <= 5'h00;
    end else if (acc && bus.write && bus.addr == PBHA_OFS_PAGE) begin
      page_flags_r <= bus.wdata[7:5];
      page_pending_r <= bus.wdata[4:0];
    end
  end

  //----------------------------------------------------------------
  // Buffer pointer
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_r <= 10'h000;
    end else if (acc && bus.write && bus.addr == PBHA_OFS_OFFSET) begin
      ptr_r <= join_ptr(page_size_code, page_pending_r, bus.wdata[7:0]);
    end else if (step_now) begin
      ptr_r <= step_ptr(page_size_code, ptr_r, step_size, page_flags_r[0]);
    end
  end

  //----------------------------------------------------------------
  // Word pairing tracker: low byte held until the high byte comes
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_open_r <= 1'b0;
      pair_low_r <= 8'h00;
    end else if (data_ok && pair_mode) begin
      pair_open_r <= (bus.addr == PBHA_OFS_DATA_LO);
      pair_low_r <= bus.wdata[7:0];
    end
  end

  //----------------------------------------------------------------
  // Buffer writes
  //----------------------------------------------------------------
  logic [PBHA_PTR_W-1:0] ptr_odd;
  assign ptr_odd = ptr_r | 10'h001;
  always_ff @(posedge pclk) begin
    if (data_ok && bus.write) begin
      if (wide_bus_select) begin
        buf_mem[ptr_r & 10'h3FE] <= byte_order_select ? bus.wdata[7:0] : bus.wdata[15:8];
        buf_mem[ptr_odd] <= byte_order_select ? bus.wdata[15:8] : bus.wdata[7:0];
      end else if (pair_mode) begin
        if (bus.addr == PBHA_OFS_DATA_HI && pair_open_r) begin
          buf_mem[ptr_r & 10'h3FE] <= byte_order_select ? pair_low_r : bus.wdata[7:0];
          buf_mem[ptr_odd] <= byte_order_select ? bus.wdata[7:0] : pair_low_r;
        end
      end else begin
        buf_mem[ptr_r] <= bus.wdata[7:0];
      end
    end
  end

  //----------------------------------------------------------------
  // Read data
  //----------------------------------------------------------------
  logic [7:0] even_b;
  logic [7:0] odd_b;
  logic [15:0] word_rd;
  assign even_b = buf_mem[ptr_r & 10'h3FE];
  assign odd_b = buf_mem[ptr_odd];
  assign word_rd = byte_order_select ? {odd_b, even_b} : {even_b, odd_b};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 16'h0000;
    end else if (acc && !bus.write) begin
      if (bus.addr == PBHA_OFS_PAGE) begin
        rdata_r <= {8'h00, page_flags_r, page_pending_r};
      end else if (bus.addr == PBHA_OFS_OFFSET) begin
        rdata_r <= {8'h00, 8'(ptr_r & (10'h3FF >> (10 - offset_width(page_size_code))))};
      end else if (is_data) begin
        if (!data_ok) begin
          rdata_r <= 16'h0000;
        end else if (wide_bus_select) begin
          rdata_r <= word_rd;
        end else if (pair_mode) begin
          rdata_r <= {8'h00, (bus.addr == PBHA_OFS_DATA_LO) ? word_rd[7:0] : word_rd[15:8]};
        end else begin
          rdata_r <= {8'h00, buf_mem[ptr_r]};
        end
      end else if (bus.addr == PBHA_OFS_SELECT) begin
        rdata_r <= {12'h000, sel_r};
      end else if (bus.addr == PBHA_OFS_CONFIG) begin
        rdata_r <= {8'h00, cfg_r & PBHA_CFG_MASK};
      end else if (bus.addr == PBHA_OFS_WINDOW) begin
        rdata_r <= window_rdata;
      end else begin
        rdata_r <= 16'h0000;
      end
    end
  end

  //----------------------------------------------------------------
  // Indirect selector and window
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= PBHA_SEL_RESET;
    end else if (acc && bus.write && bus.addr == PBHA_OFS_SELECT) begin
      sel_r <= bus.wdata[3:0];
    end
  end
  assign indirect_select = sel_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_write <= 1'b0;
      window_wdata <= 16'h0000;
    end else begin
      window_write <= acc & bus.write & (bus.addr == PBHA_OFS_WINDOW) &
          (sel_r != PBHA_SEL_NEXT_ID);
      window_wdata <= bus.wdata;
    end
  end

  //----------------------------------------------------------------
  // Configuration register, strap captured after reset release
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= PBHA_CFG_RESET_BASE;
      strap_done_r <= 1'b0;
      pulse_reset_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      cfg_r[PBHA_BIT_ONLINE] <= online_strap;
    end else if (acc && bus.write && bus.addr == PBHA_OFS_CONFIG) begin
      cfg_r <= bus.wdata[7:0] & PBHA_CFG_MASK;
      pulse_reset_r <= bus.wdata[PBHA_BIT_ONLINE] & ~cfg_r[PBHA_BIT_ONLINE];
    end else begin
      pulse_reset_r <= 1'b0;
    end
  end
  assign sw_reset = cfg_r[PBHA_BIT_SW_RESET] | pulse_reset_r;
  assign network_online = cfg_r[PBHA_BIT_ONLINE];
  assign timeout_select_low = cfg_r[PBHA_BIT_TMO_LOW];
  assign timeout_select_high = cfg_r[PBHA_BIT_TMO_HIGH];
  assign backplane_signalling = cfg_r[PBHA_BIT_BACKPLANE];
endmodule

// file: design/pbha_host.sv
// Host end: APB-controlled bus master that performs single accesses on the parallel bus
module pbha_host
  import pbha_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  pbha_bus_if.host bus // Parallel host bus
);
  //----------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------
  pbha_state_type state_r;
  logic [3:0] addr_r;
  logic is_read_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic done_r;
  logic apb_wr;
  logic go;
  assign apb_wr = psel & penable & pwrite;
  assign go = apb_wr & (paddr == PBHA_APB_CMD) & pwdata[PBHA_CMD_GO] & (state_r == PBHA_ST_IDLE);

  //----------------------------------------------------------------
  // APB slave: zero wait state, unmapped reads zero and error
  //----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != PBHA_APB_CMD) & (paddr != PBHA_APB_WDATA) &
      (paddr != PBHA_APB_RDATA) & (paddr != PBHA_APB_STATUS);
  always_comb begin
    if (paddr == PBHA_APB_CMD) begin
      prdata = {22'h000000, is_read_r, 1'b0, 4'h0, addr_r};
    end else if (paddr == PBHA_APB_WDATA) begin
      prdata = {16'h0000, wdata_r};
    end else if (paddr == PBHA_APB_RDATA) begin
      prdata = {16'h0000, rdata_r};
    end else if (paddr == PBHA_APB_STATUS) begin
      prdata = {30'h00000000, done_r, state_r != PBHA_ST_IDLE};
    end else begin
      prdata = 32'h0000_0000;
    end
  end

  // Command and write data capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 4'h0;
      is_read_r <= 1'b0;
      wdata_r <= 16'h0000;
    end else if (go) begin
      addr_r <= pwdata[3:0];
      is_read_r <= pwdata[PBHA_CMD_READ];
    end else if (apb_wr && paddr == PBHA_APB_WDATA && state_r == PBHA_ST_IDLE) begin
      wdata_r <= pwdata[15:0];
    end
  end

  //----------------------------------------------------------------
  // Bus sequencer: strobe until ack, then hold and done cycles before idle
  //----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PBHA_ST_IDLE;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      case (state_r)
        PBHA_ST_IDLE: begin
          if (go) begin
            state_r <= PBHA_ST_ACCESS;
            done_r <= 1'b0;
          end
        end
        PBHA_ST_ACCESS: begin
          if (bus.ack) begin
            state_r <= PBHA_ST_HOLD;
          end
        end
        PBHA_ST_HOLD: begin
          rdata_r <= bus.rdata;
          state_r <= PBHA_ST_DONE;
        end
        PBHA_ST_DONE: begin
          done_r <= 1'b1;
          state_r <= PBHA_ST_IDLE;
        end
        default: begin
          state_r <= PBHA_ST_IDLE;
        end
      endcase
    end
  end
  assign bus.strobe = (state_r == PBHA_ST_ACCESS) & ~bus.ack;
  assign bus.write = ~is_read_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
endmodule

// file: pkg/pbha_bus_if.sv
// Interface: parallel host bus between the controller and the packet buffer port
interface pbha_bus_if;
  logic strobe;
  logic write;
  logic [3:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  modport device (input strobe, input write, input addr, input wdata, output rdata, output ack);
  modport host (output strobe, output write, output addr, output wdata, input rdata, input ack);
endinterface

// file: pkg/pbha_pkg.sv
// Package: register map, field positions, reset values and modes of the packet buffer port
package pbha_pkg;
  // Register byte offsets on the parallel bus
  localparam logic [3:0] PBHA_OFS_PAGE = 4'h4;
  localparam logic [3:0] PBHA_OFS_OFFSET = 4'h6;
  localparam logic [3:0] PBHA_OFS_DATA_LO = 4'h8;
  localparam logic [3:0] PBHA_OFS_DATA_HI = 4'h9;
  localparam logic [3:0] PBHA_OFS_SELECT = 4'hA;
  localparam logic [3:0] PBHA_OFS_CONFIG = 4'hC;
  localparam logic [3:0] PBHA_OFS_WINDOW = 4'hE;
  // Page register fields
  localparam int PBHA_BIT_DIR_READ = 7;
  localparam int PBHA_BIT_AUTO_STEP = 6;
  localparam int PBHA_BIT_WRAP = 5;
  localparam int PBHA_PAGE_W = 5;
  localparam int PBHA_OFFSET_W = 8;
  localparam int PBHA_PTR_W = 10;
  localparam int PBHA_SEL_W = 4;
  localparam int PBHA_BUF_BYTES = 1024;
  // Configuration register fields
  localparam int PBHA_BIT_SW_RESET = 7;
  localparam int PBHA_BIT_ONLINE = 5;
  localparam int PBHA_BIT_TMO_LOW = 4;
  localparam int PBHA_BIT_TMO_HIGH = 3;
  localparam int PBHA_BIT_BACKPLANE = 2;
  localparam logic [7:0] PBHA_CFG_MASK = 8'hBC;
  localparam logic [7:0] PBHA_CFG_RESET_BASE = 8'h1C;
  // Indirect selector reset and legal codes
  localparam logic [3:0] PBHA_SEL_RESET = 4'h0;
  localparam logic [3:0] PBHA_SEL_TENT_ID = 4'h0;
  localparam logic [3:0] PBHA_SEL_NODE_ID = 4'h1;
  localparam logic [3:0] PBHA_SEL_SETUP1 = 4'h2;
  localparam logic [3:0] PBHA_SEL_NEXT_ID = 4'h3;
  localparam logic [3:0] PBHA_SEL_SETUP2 = 4'h4;
  localparam logic [3:0] PBHA_SEL_GPIO_DATA = 4'hA;
  localparam logic [3:0] PBHA_SEL_GPIO_DIR = 4'hB;
  // Step sizes of the buffer pointer
  localparam logic [9:0] PBHA_STEP_BYTE = 10'h001;
  localparam logic [9:0] PBHA_STEP_WORD = 10'h002;
  // Page size codes
  typedef enum logic [1:0] {
    PBHA_PS_256 = 2'b00,
    PBHA_PS_128 = 2'b01,
    PBHA_PS_64 = 2'b10,
    PBHA_PS_32 = 2'b11
  } pbha_page_size_type;
  // Host bus sequencer states
  typedef enum logic [1:0] {
    PBHA_ST_IDLE = 2'b00,
    PBHA_ST_ACCESS = 2'b01,
    PBHA_ST_HOLD = 2'b10,
    PBHA_ST_DONE = 2'b11
  } pbha_state_type;
  // APB register offsets of the host controller
  localparam logic [11:0] PBHA_APB_CMD = 12'h000;
  localparam logic [11:0] PBHA_APB_WDATA = 12'h004;
  localparam logic [11:0] PBHA_APB_RDATA = 12'h008;
  localparam logic [11:0] PBHA_APB_STATUS = 12'h00C;
  localparam int PBHA_CMD_GO = 8;
  localparam int PBHA_CMD_READ = 9;
endpackage

// file: verification/pbha_bus_asserts.sv
// Checker: handshake and register relations on the parallel host bus
module pbha_bus_asserts
  import pbha_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Reset, active low
  input wire logic strobe, // Host request
  input wire logic write, // Write when high
  input wire logic [3:0] addr, // Register offset
  input wire logic [15:0] wdata, // Write data
  input wire logic [15:0] rdata, // Read data
  input wire logic ack // Device answer
);
  logic dir_r;
  logic dir_set_r;
  logic [3:0] sel_r;
  logic rd_ack;
  logic take;
  // Read answer and taken request in this cycle
  assign rd_ack = ack && !write;
  assign take = strobe && !ack && write;
  // Mirror of direction flag and selector as the host writes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_r <= 1'b0;
      dir_set_r <= 1'b0;
      sel_r <= PBHA_SEL_RESET;
    end else if (take && addr == PBHA_OFS_PAGE) begin
      dir_r <= wdata[PBHA_BIT_DIR_READ];
      dir_set_r <= 1'b1;
    end else if (take && addr == PBHA_OFS_SELECT) begin
      sel_r <= wdata[3:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // A request and its one-cycle answer
  sequence s_take;
    strobe && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence
  a_ack_follows_take: assert property (s_take |=> s_answer)
    else $error("ack did not follow a taken request for one cycle");
  a_ack_has_cause: assert property (ack |-> $past(strobe) && !$past(ack))
    else $error("ack without a pending request");
  a_strobe_drops: assert property (ack |=> !strobe)
    else $error("strobe still high after ack");
  a_rdata_holds: assert property (!rd_ack |-> $stable(rdata))
    else $error("read data changed outside a read answer");
  a_page_resv_zero: assert property (rd_ack && (addr == PBHA_OFS_PAGE ||
    addr == PBHA_OFS_OFFSET) |-> rdata[15:8] == 8'h00)
    else $error("pointer register upper byte not zero");
  a_cfg_resv_zero: assert property (rd_ack && addr == PBHA_OFS_CONFIG |->
    (rdata & ~{8'h00, PBHA_CFG_MASK}) == 16'h0000)
    else $error("configuration reserved bits not zero");
  a_sel_readback: assert property (rd_ack && addr == PBHA_OFS_SELECT |->
    rdata == {12'h000, sel_r})
    else $error("selector read differs from last write");
  a_dir_read_zero: assert property (rd_ack && dir_set_r && !dir_r &&
    (addr == PBHA_OFS_DATA_LO || addr == PBHA_OFS_DATA_HI) |-> rdata == 16'h0000)
    else $error("data read in write direction returned data");
endmodule

// file: verification/tb_top.sv
// Testbench: APB driven host end joined to the device end, register sequences
module tb_top
  import pbha_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, scr;
  logic wide_bus_select, word_pairing_mode, byte_order_select, online_strap;
  logic [1:0] page_size_code;
  logic [15:0] window_rdata, window_wdata, rq;
  logic [3:0] indirect_select;
  logic window_write, sw_reset, network_online;
  logic timeout_select_low, timeout_select_high, backplane_signalling;
  int errors, n_tests, sw_cnt, ww_cnt;
  logic [4:0] pg_t[3] = '{5'h01, 5'h03, 5'h1F};
  logic wp_t[3] = '{1'b1, 1'b0, 1'b1};
  logic [4:0] dst_t[3] = '{5'h02, 5'h03, 5'h00};
  pbha_page_size_type ps_t[3] = '{PBHA_PS_256, PBHA_PS_128, PBHA_PS_64};
  logic [4:0] psp_t[3] = '{5'h05, 5'h0A, 5'h14};
  logic [3:0] sel_t[7] = '{PBHA_SEL_TENT_ID, PBHA_SEL_NODE_ID, PBHA_SEL_SETUP1,
    PBHA_SEL_NEXT_ID, PBHA_SEL_SETUP2, PBHA_SEL_GPIO_DATA, PBHA_SEL_GPIO_DIR};
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH t=%0t got %h expected %h", $time, got, exp); end end
  pbha_bus_if bus_i();
  pbha_host i_pbha_host(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus(bus_i.host));
  pbha_device i_pbha_device(.pclk, .presetn, .bus(bus_i.device), .wide_bus_select,
    .word_pairing_mode, .byte_order_select, .page_size_code, .online_strap,
    .window_rdata, .indirect_select, .window_write, .window_wdata, .sw_reset,
    .network_online, .timeout_select_low, .timeout_select_high, .backplane_signalling);
  pbha_bus_asserts i_pbha_bus_asserts(.pclk, .presetn, .strobe(bus_i.strobe),
    .write(bus_i.write), .addr(bus_i.addr), .wdata(bus_i.wdata), .rdata(bus_i.rdata),
    .ack(bus_i.ack));
  // ----------------------------------------
  // Clock, software reset counter, watchdog
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Count cycles with software reset high
  always @(posedge pclk) if (sw_reset === 1'b1) sw_cnt <= sw_cnt + 1;
  // Count window write pulses
  always @(posedge pclk) if (window_write === 1'b1) ww_cnt <= ww_cnt + 1;
  // Cut a hang short
  initial begin
    #300_000;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin errors++; $display("MISMATCH t=%0t no ready", $time); end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One access on the parallel bus through the host end
  task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] d);
    logic [31:0] s;
    int n;
    if (wr) apb(1'b1, PBHA_APB_WDATA, {16'h0000, d}, s);
    apb(1'b1, PBHA_APB_CMD, {22'h00_0000, !wr, 1'b1, 4'h0, a}, s);
    n = 0;
    do begin apb(1'b0, PBHA_APB_STATUS, 32'h0000_0000, s); n++; end
      while ((s[1] !== 1'b1 || s[0] !== 1'b0) && n < 50);
    if (n >= 50) begin errors++; $display("MISMATCH t=%0t bus access hung", $time); end
    apb(1'b0, PBHA_APB_RDATA, 32'h0000_0000, s);
    rq = s[15:0];
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic chk_rd(input logic [3:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    `CHK(rq, e)
  endtask
  task automatic ptr(input logic [7:0] p, input logic [7:0] o);
    wr(PBHA_OFS_PAGE, {8'h00, p});
    wr(PBHA_OFS_OFFSET, {8'h00, o});
  endtask
  task automatic final_report();
    $display("Errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sw_cnt, ww_cnt} = '0;
    {word_pairing_mode, byte_order_select, online_strap} = 3'b000;
    wide_bus_select = 1'b1;
    page_size_code = PBHA_PS_32;
    window_rdata = 16'h0000;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_rd(PBHA_OFS_CONFIG, 16'h001C);
    `CHK(backplane_signalling, 1'b1)
    chk_rd(PBHA_OFS_SELECT, 16'h0000);
    // Word writes with auto-step, read back in order
    ptr(8'h61, 8'h00);
    for (int i = 0; i < 3; i++) wr(PBHA_OFS_DATA_LO, 16'hA000 | 16'(i));
    ptr(8'hE1, 8'h00);
    for (int i = 0; i < 3; i++) chk_rd(PBHA_OFS_DATA_LO, 16'hA000 | 16'(i));
    chk_rd(PBHA_OFS_OFFSET, 16'h0006);
    // Overflow at the end of a page, to next page, same page, and page 0
    foreach (pg_t[k]) begin
      ptr({2'b01, wp_t[k], pg_t[k]}, 8'h1E);
      wr(PBHA_OFS_DATA_LO, 16'h5500);
      wr(PBHA_OFS_DATA_LO, 16'h6600 | 16'(k));
      chk_rd(PBHA_OFS_OFFSET, 16'h0002);
      ptr({3'b110, dst_t[k]}, 8'h00);
      chk_rd(PBHA_OFS_DATA_LO, 16'h6600 | 16'(k));
    end
    // Pending page, held pointer, accesses against the direction flag
    ptr(8'h01, 8'h04);
    wr(PBHA_OFS_DATA_LO, 16'h1111);
    wr(PBHA_OFS_PAGE, 16'h0005);
    wr(PBHA_OFS_DATA_LO, 16'h2222);
    ptr(8'h81, 8'h04);
    chk_rd(PBHA_OFS_DATA_LO, 16'h2222);
    wr(PBHA_OFS_DATA_LO, 16'h3333);
    chk_rd(PBHA_OFS_DATA_LO, 16'h2222);
    ptr(8'h01, 8'h04);
    chk_rd(PBHA_OFS_DATA_LO, 16'h0000);
    // Page size splits, upper page bits discarded
    ptr(8'h08, 8'h00);
    wr(PBHA_OFS_DATA_LO, 16'h7777);
    foreach (ps_t[k]) begin
      @(posedge pclk) page_size_code <= ps_t[k];
      ptr({3'b100, psp_t[k]}, 8'h00);
      chk_rd(PBHA_OFS_DATA_LO, 16'h7777);
    end
    // Byte mode: single bytes, upper half zero
    @(posedge pclk) {wide_bus_select, page_size_code} <= {1'b0, PBHA_PS_32};
    ptr(8'h42, 8'h00);
    wr(PBHA_OFS_DATA_LO, 16'hFFAB);
    wr(PBHA_OFS_DATA_HI, 16'hFFCD);
    chk_rd(PBHA_OFS_OFFSET, 16'h0002);
    ptr(8'hC2, 8'h00);
    chk_rd(PBHA_OFS_DATA_HI, 16'h00AB);
    chk_rd(PBHA_OFS_DATA_LO, 16'h00CD);
    // Paired bytes under both byte orders, lone high byte dropped
    for (int b = 0; b < 2; b++) begin
      @(posedge pclk) {word_pairing_mode, byte_order_select} <= {1'b1, 1'(b)};
      ptr(8'h43, 8'h00);
      wr(PBHA_OFS_DATA_HI, 16'h0099);
      wr(PBHA_OFS_DATA_LO, 16'h0011);
      wr(PBHA_OFS_DATA_HI, 16'h0022);
      chk_rd(PBHA_OFS_OFFSET, 16'h0002);
      ptr(8'hC3, 8'h00);
      chk_rd(PBHA_OFS_DATA_LO, 16'h0011);
      chk_rd(PBHA_OFS_DATA_HI, 16'h0022);
      @(posedge pclk) word_pairing_mode <= 1'b0;
      ptr(8'hC3, 8'h00);
      chk_rd(PBHA_OFS_DATA_LO, (b == 1) ? 16'h0011 : 16'h0022);
      chk_rd(PBHA_OFS_DATA_LO, (b == 1) ? 16'h0022 : 16'h0011);
    end
    // Selector codes and the indirect window
    foreach (sel_t[k]) begin
      @(posedge pclk) window_rdata <= 16'hC000 | {12'h000, sel_t[k]};
      wr(PBHA_OFS_SELECT, 16'hFFF0 | {12'h000, sel_t[k]});
      `CHK(indirect_select, sel_t[k])
      chk_rd(PBHA_OFS_SELECT, {12'h000, sel_t[k]});
      chk_rd(PBHA_OFS_WINDOW, 16'hC000 | {12'h000, sel_t[k]});
    end
    ww_cnt = 0;
    wr(PBHA_OFS_WINDOW, 16'h5A5A);
    `CHK(window_wdata, 16'h5A5A)
    `CHK(ww_cnt, 1)
    wr(PBHA_OFS_SELECT, {12'h000, PBHA_SEL_NEXT_ID});
    wr(PBHA_OFS_WINDOW, 16'h1234);
    `CHK(ww_cnt, 1)
    chk_rd(4'h2, 16'h0000);
    apb(1'b0, 12'h010, 32'h0000_0000, scr);
    `CHK(last_err, 1'b1)
    `CHK(scr, 32'h0000_0000)
    // Configuration: going online, software reset, signalling
    sw_cnt = 0;
    wr(PBHA_OFS_CONFIG, 16'hFF7F);
    `CHK(sw_cnt, 1)
    chk_rd(PBHA_OFS_CONFIG, 16'h003C);
    `CHK({network_online, timeout_select_low, timeout_select_high}, 3'b111)
    wr(PBHA_OFS_CONFIG, 16'h00BC);
    `CHK(sw_reset, 1'b1)
    wr(PBHA_OFS_CONFIG, 16'h003C);
    `CHK(sw_reset, 1'b0)
    sw_cnt = 0;
    wr(PBHA_OFS_CONFIG, 16'h0018);
    `CHK(sw_cnt, 0)
    `CHK(backplane_signalling, 1'b0)
    // Reset again in mid-run with the online strap set
    @(posedge pclk) {presetn, online_strap} <= 2'b01;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk_rd(PBHA_OFS_CONFIG, 16'h003C);
    `CHK(network_online, 1'b1)
    final_report();
  end
endmodule
